//--- logic/nc_word_master.sv
`timescale 1ns/1ns
module nc_word_master
    import nc_word_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    nc_word_if.master        link,
    input  wire logic        start,
    input  wire logic        rw,
    input  wire logic [7:0]  menu,
    input  wire logic [7:0]  param,
    input  wire logic [31:0] wr_value,
    output logic             busy,
    output logic             done,
    output logic             err,
    output logic             timeout,
    output logic [31:0]      rd_value
);
    import nc_word_pkg::*;

    typedef struct packed {
        master_state_t st;
        logic [3:0]    stamp;
        logic          rw;
        logic [7:0]    menu;
        logic [7:0]    param;
        logic [31:0]   val;
        logic [15:0]   word;
        logic [15:0]   tmr;
        logic          done;
        logic          err;
        logic          tout;
    } mst_state_t;

    mst_state_t s_ff;
    mst_state_t nxt_s;
    logic [7:0] pl;

    // ------------------------------------------------------------
    // Payload for current stamp
    // ------------------------------------------------------------
    always_comb
    begin
        pl = 8'h00;
        if (s_ff.stamp == STAMP_MENU)
            pl = s_ff.menu;
        else if (s_ff.stamp == STAMP_PARAM)
            pl = s_ff.param;
        else if (s_ff.rw == RW_WRITE)
            pl = s_ff.val[8*(STAMP_B0-s_ff.stamp) +: 8];
    end

    // ------------------------------------------------------------
    // Telegram sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_s      = s_ff;
        nxt_s.done = 1'b0;
        case (s_ff.st)
            M_IDLE:
                if (start)
                begin
                    nxt_s.rw    = rw;
                    nxt_s.menu  = menu;
                    nxt_s.param = param;
                    nxt_s.val   = wr_value;
                    nxt_s.stamp = STAMP_MENU;
                    nxt_s.err   = 1'b0;
                    nxt_s.tout  = 1'b0;
                    nxt_s.st    = M_SEND;
                end
            M_SEND:
            begin
                nxt_s.word = {s_ff.rw, 3'b000, s_ff.stamp, pl};
                nxt_s.tmr  = 16'h0000;
                nxt_s.st   = M_WAIT;
            end
            M_WAIT:
                if (link.in_word[STAMP_HI:STAMP_LO] == s_ff.stamp)
                begin
                    if (s_ff.rw == RW_READ && s_ff.stamp >= STAMP_B3)
                        nxt_s.val[8*(STAMP_B0-s_ff.stamp) +: 8] = link.in_word[7:0];
                    if (link.in_word[ERR_BIT])
                    begin
                        nxt_s.err = 1'b1;
                        nxt_s.st  = M_ABORT;
                    end
                    else if (s_ff.stamp == STAMP_B0)
                    begin
                        nxt_s.done = 1'b1;
                        nxt_s.st   = M_ABORT;             // Zero word readies next message
                    end
                    else
                    begin
                        nxt_s.stamp = s_ff.stamp + 4'h1;
                        nxt_s.st    = M_SEND;
                    end
                end
                else if (s_ff.tmr == HOST_TIMEOUT)
                begin
                    nxt_s.tout = 1'b1;
                    nxt_s.st   = M_ABORT;
                end
                else
                    nxt_s.tmr = s_ff.tmr + 16'h0001;
            M_ABORT:
            begin
                nxt_s.word = ABORT_WORD;
                nxt_s.st   = M_IDLE;
            end
            default:
                nxt_s.st = M_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_ff    <= '0;
            s_ff.st <= M_IDLE;
        end
        else
            s_ff <= nxt_s;
    end

    assign link.out_word = s_ff.word;
    assign busy          = (s_ff.st != M_IDLE);
    assign done          = s_ff.done;
    assign err           = s_ff.err;
    assign timeout       = s_ff.tout;
    assign rd_value      = s_ff.val;
endmodule

//--- logic/nc_word_pkg.sv
package nc_word_pkg;

    // ------------------------------------------------------------
    // Telegram word layout
    // ------------------------------------------------------------
    localparam int        WORD_W        = 16;
    localparam int        RW_BIT        = 15;
    localparam int        ERR_BIT       = 14;
    localparam int        STAMP_HI      = 11;
    localparam int        STAMP_LO      = 8;
    localparam int        DATA_HI       = 7;
    localparam int        DATA_LO       = 0;
    localparam logic [15:0] ABORT_WORD  = 16'h0000;
    localparam logic [15:0] WORD_RST    = 16'h0000;
    localparam logic [3:0]  STAMP_MENU  = 4'h1;
    localparam logic [3:0]  STAMP_PARAM = 4'h2;
    localparam logic [3:0]  STAMP_B3    = 4'h3;
    localparam logic [3:0]  STAMP_B2    = 4'h4;
    localparam logic [3:0]  STAMP_B1    = 4'h5;
    localparam logic [3:0]  STAMP_B0    = 4'h6;
    localparam logic        RW_WRITE    = 1'b0;
    localparam logic        RW_READ     = 1'b1;

    // ------------------------------------------------------------
    // Module configuration
    // ------------------------------------------------------------
    localparam logic [7:0]  CFG_MENU        = 8'h3C;
    localparam logic [7:0]  RESET_PARAM     = 8'h20;
    localparam logic [31:0] RESET_VALUE     = 32'h0000_0001;
    localparam logic [15:0] HOST_TIMEOUT    = 16'h0FA0;

    typedef enum logic [1:0] {
        M_IDLE,
        M_SEND,
        M_WAIT,
        M_ABORT
    } master_state_t;

endpackage

//--- logic/nc_word_if.sv
`timescale 1ns/1ns
interface nc_word_if;
    logic [15:0] out_word;
    logic [15:0] in_word;

    modport device (input out_word, output in_word);
    modport master (output out_word, input in_word);
endinterface

//--- logic/nc_value_asm.sv
`timescale 1ns/1ns
module nc_value_asm
    import nc_word_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        clr,
    input  wire logic        load,
    input  wire logic [1:0]  sel,
    input  wire logic [7:0]  byte_in,
    output logic [31:0]      value
);
    // ------------------------------------------------------------
    // Byte lanes, one per generate entry
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < 4; i++)
        begin : g_lane
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                    value[8*i+7:8*i] <= 8'h00;
                else if (clr)
                    value[8*i+7:8*i] <= 8'h00;
                else if (load && sel == 2'(i))
                    value[8*i+7:8*i] <= byte_in;
            end
        end
    endgenerate
endmodule

//--- logic/nc_word_device.sv
`timescale 1ns/1ns
module nc_word_device
    import nc_word_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    nc_word_if.device        link,
    output logic             par_wr,
    output logic [7:0]       par_menu,
    output logic [7:0]       par_num,
    output logic [31:0]      par_value,
    input  wire logic        par_ok,
    input  wire logic [31:0] par_rd_value,
    output logic             cfg_pending,
    output logic             module_reset
);
    import nc_word_pkg::*;

    typedef struct packed {
        logic [3:0]  expect_stamp;
        logic        rw;
        logic [7:0]  menu;
        logic [7:0]  param;
        logic [15:0] echo;
        logic        wr;
        logic        pend;
        logic        mrst;
    } dev_state_t;

    dev_state_t st_ff;
    dev_state_t nxt_st;

    logic [3:0]  stamp;
    logic [7:0]  payload;
    logic        accept;
    logic        abort;
    logic        asm_load;
    logic [1:0]  asm_sel;
    logic [31:0] wr_value;

    // ------------------------------------------------------------
    // Telegram decode
    // ------------------------------------------------------------
    assign stamp   = link.out_word[STAMP_HI:STAMP_LO];
    assign payload = link.out_word[DATA_HI:DATA_LO];
    assign abort   = (link.out_word == ABORT_WORD);
    // Repeats of the current word re-match nothing, so a held word is harmless
    assign accept  = !abort && (stamp == st_ff.expect_stamp);

    // Write bytes land in lanes; stamp three is the top byte
    assign asm_load = accept && st_ff.rw == RW_WRITE && stamp >= STAMP_B3;
    assign asm_sel  = 2'(STAMP_B0 - stamp);

    nc_value_asm u_asm (
        .clk     (clk),
        .rst     (rst),
        .clr     (abort),
        .load    (asm_load),
        .sel     (asm_sel),
        .byte_in (payload),
        .value   (wr_value)
    );

    // ------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_st      = st_ff;
        nxt_st.wr   = 1'b0;
        nxt_st.mrst = 1'b0;
        if (abort)
        begin
            nxt_st.expect_stamp = STAMP_MENU;
            nxt_st.menu         = 8'h00;
            nxt_st.param        = 8'h00;
            nxt_st.echo         = WORD_RST;
        end
        else if (accept)
        begin
            nxt_st.expect_stamp = stamp + 4'h1;
            nxt_st.echo         = link.out_word;
            if (stamp == STAMP_MENU)
            begin
                nxt_st.rw   = link.out_word[RW_BIT];
                nxt_st.menu = payload;
            end
            if (stamp == STAMP_PARAM)
                nxt_st.param = payload;
            if (st_ff.rw == RW_READ && stamp >= STAMP_B3)
                nxt_st.echo[DATA_HI:DATA_LO] = par_rd_value[8*(STAMP_B0-stamp) +: 8];
            if (stamp == STAMP_B0)
            begin
                nxt_st.expect_stamp = 4'hF;               // Park until zero word
                if (st_ff.rw == RW_WRITE)
                begin
                    nxt_st.wr = 1'b1;
                    nxt_st.echo[ERR_BIT] = !par_ok;
                    // Config writes mark pending, the module reset write clears it; applied on module reset
                    if (st_ff.menu == CFG_MENU)
                        nxt_st.pend = 1'b1;
                    if (st_ff.menu == CFG_MENU && st_ff.param == RESET_PARAM
                        && {wr_value[31:8], payload} == RESET_VALUE && par_ok)
                    begin
                        nxt_st.mrst = 1'b1;
                        nxt_st.pend = 1'b0;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_ff              <= '0;
            st_ff.expect_stamp <= STAMP_MENU;
            st_ff.rw           <= RW_READ;
        end
        else
            st_ff <= nxt_st;
    end

    // ------------------------------------------------------------
    // Parameter write strobe
    // ------------------------------------------------------------
    // Combinational on the final telegram so par_ok answers in the
    // same cycle; a registered strobe would cost a second cycle of
    // out_word hold, which the master does not promise.
    // Lasts one cycle only: acceptance parks the expected stamp at
    // the next edge, so a held final word cannot strobe again.
    assign par_wr = asm_load && stamp == STAMP_B0;

    // ------------------------------------------------------------
    // Parameter address
    // ------------------------------------------------------------
    // Menu and parameter stay registered for the whole message,
    // so the drive sees a stable address while par_wr is high.
    // Both clear on a zero word so a cut message leaves no address.
    assign par_menu = st_ff.menu;
    assign par_num  = st_ff.param;

    // ------------------------------------------------------------
    // Parameter value
    // ------------------------------------------------------------
    // Top three bytes come from the lanes, the low byte straight
    // from the current telegram, so the value is whole in the very
    // cycle of the strobe. No scaling here: the drive places any
    // decimal point itself, the channel moves a raw integer.
    assign par_value = {wr_value[31:8], payload};

    // ------------------------------------------------------------
    // Echo word
    // ------------------------------------------------------------
    // The echo is registered, so the master sees it one edge after
    // acceptance and never a half-updated word.
    // On an error echo the master uses the stamp bits 11:8 and bit 14.
    assign link.in_word = st_ff.echo;

    // ------------------------------------------------------------
    // Configuration status
    // ------------------------------------------------------------
    // Pending stays up until the module reset pulse, so software
    // can tell that written settings are not yet in force.
    // The reset pulse is one cycle wide and starts on the same edge as the echo.
    assign cfg_pending  = st_ff.pend;
    assign module_reset = st_ff.mrst;
endmodule

//--- tb/nc_word_asserts.sv
`timescale 1ns/1ns
module nc_word_asserts
    import nc_word_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [15:0] out_word,
    input  wire logic [15:0] in_word,
    input  wire logic        par_wr,
    input  wire logic        par_ok,
    input  wire logic [7:0]  par_menu,
    input  wire logic [7:0]  par_num,
    input  wire logic [31:0] par_value,
    input  wire logic        module_reset
);
    // ----------
    // Link and parameter write checks
    // ----------
    // One domain, so clock and reset are given once
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Error echoes (bit 14 set) are left out of the stamp check
    echo_stamp_a: assert property ($changed(in_word) && in_word != 16'h0000 && !in_word[14]
        |-> in_word[11:8] == $past(out_word[11:8])) else $error("echo stamp wrong");
    stamp_step_a: assert property ($changed(out_word) && out_word != 16'h0000
        |-> out_word[11:8] == ($past(out_word[11:8]) + 4'h1)) else $error("stamp skipped");
    wait_echo_a: assert property ($changed(out_word) && out_word != 16'h0000
        && $past(out_word) != 16'h0000 |-> $past(in_word[11:8]) == $past(out_word[11:8]))
        else $error("sent before echo");
    zero_abort_a: assert property (out_word == 16'h0000 |=> in_word == 16'h0000)
        else $error("zero word not idle");
    final_write_a: assert property (par_wr |-> out_word[11:8] == STAMP_B0
        && out_word[RW_BIT] == RW_WRITE) else $error("write on wrong telegram");
    low_byte_a: assert property (par_wr |-> par_value[7:0] == out_word[7:0])
        else $error("low byte wrong");
    err_flag_a: assert property (par_wr |=> in_word[ERR_BIT] == !$past(par_ok))
        else $error("error flag wrong");
    ok_echo_a: assert property (par_wr && par_ok |=> in_word == $past(out_word))
        else $error("final echo wrong");
    cfg_reset_a: assert property (par_wr && par_ok && par_menu == CFG_MENU
        && par_num == RESET_PARAM && par_value == RESET_VALUE |=> module_reset)
        else $error("no module reset");
    cover property (par_wr && par_ok);
    cover property (par_wr && !par_ok);
    cover property (module_reset);
endmodule

//--- tb/tb_noncyclic_param_word_channel.sv
`timescale 1ns/1ns
module tb_noncyclic_param_word_channel;
    import nc_word_pkg::*;
    typedef struct packed {logic rd; logic e; logic [7:0] m; logic [7:0] p; logic [31:0] v;} exp_t;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        start, rw, par_ok, par_wr, busy, done, err, timeout, cfg_pending, module_reset;
    logic [7:0]  menu, param, par_menu, par_num, b_menu;
    logic [31:0] wr_value, rd_value, par_value, par_rd_value;
    integer      seed = 32'h6EFC;
    int          miscompares = 0;
    int          check_count = 0;
    int          mr_count = 0;
    logic        last_err = 1'b0;
    exp_t        wq[$];
    exp_t        dq[$];
    exp_t        x;
    exp_t        y;
    nc_word_if   link_a();
    nc_word_if   link_b();
    // ----------
    // Ends and checker
    // ----------
    always #4 clk = ~clk;
    nc_word_master nc_word_master_i (.clk(clk), .rst(rst), .link(link_a), .start(start), .rw(rw),
        .menu(menu), .param(param), .wr_value(wr_value), .busy(busy), .done(done), .err(err),
        .timeout(timeout), .rd_value(rd_value));
    nc_word_device nc_word_device_i (.clk(clk), .rst(rst), .link(link_a), .par_wr(par_wr),
        .par_menu(par_menu), .par_num(par_num), .par_value(par_value), .par_ok(par_ok),
        .par_rd_value(par_rd_value), .cfg_pending(cfg_pending), .module_reset(module_reset));
    // Second device is fed bad sequences straight from the bench
    nc_word_device nc_word_device_b_i (.clk(clk), .rst(rst), .link(link_b), .par_wr(),
        .par_menu(b_menu), .par_num(), .par_value(), .par_ok(1'b1), .par_rd_value(32'h0),
        .cfg_pending(), .module_reset());
    nc_word_asserts nc_word_asserts_i (.clk(clk), .rst(rst), .out_word(link_a.out_word),
        .in_word(link_a.in_word), .par_wr(par_wr), .par_ok(par_ok), .par_menu(par_menu),
        .par_num(par_num), .par_value(par_value), .module_reset(module_reset));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task give_verdict;
        if (miscompares == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // One message through the master; read data doubles as the write value
    task run(input logic r, input logic [7:0] m, input logic [7:0] p, input logic [31:0] v,
             input logic ok);
        int n;
        x = '{rd: r, e: !ok, m: m, p: p, v: v};
        if (!r)
            wq.push_back(x);
        dq.push_back(x);
        rw = r; menu = m; param = p; wr_value = v; par_ok = ok; par_rd_value = v; start = 1'b1;
        @(posedge clk);
        #1 start = 1'b0;
        n = 0;
        while (done !== 1'b1 && err !== 1'b1 && n < 300)
        begin
            @(posedge clk);
            #1 n++;
        end
        chk(32'(n < 300), 32'h1);
        @(posedge clk);
        #1 chk(32'(timeout), 32'h0);
        chk(32'(busy), 32'h0);
    endtask
    task poke(input logic [15:0] w, input logic [15:0] e);
        link_b.out_word = w;
        repeat (2) @(posedge clk);
        #1 chk(link_b.in_word, e);
    endtask
    // Sampled late in the cycle so the driver's +1 updates have landed
    always @(posedge clk)
    begin
        #2;
        if (par_wr === 1'b1)
        begin
            y = (wq.size() > 0) ? wq.pop_front() : '1;
            chk(par_value, y.v);
            chk(32'({par_menu, par_num}), 32'({y.m, y.p}));
        end
        // A failed message ends on the error flag, not on done
        if (done === 1'b1 || (err === 1'b1 && last_err !== 1'b1))
        begin
            y = (dq.size() > 0) ? dq.pop_front() : '1;
            chk(32'(err), 32'(y.e));
            if (y.rd)
                chk(rd_value, y.v);
        end
        last_err = err;
        if (module_reset === 1'b1)
            mr_count++;
    end
    initial
    begin
        start = 1'b0; rw = 1'b0; menu = 8'h00; param = 8'h00; wr_value = 32'h0;
        par_ok = 1'b1; par_rd_value = 32'h0; link_b.out_word = 16'h0000;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        run(RW_WRITE, 8'h01, 8'h15, 32'h0001_EA63, 1'b1);
        for (int i = 0; i < 3; i++)
            run(RW_WRITE, 8'($random(seed)) & 8'h1F, 8'($random(seed)), $random(seed), 1'b1);
        run(RW_WRITE, 8'h01, 8'h15, $random(seed), 1'b0);
        run(RW_READ, 8'h02, 8'h01, $random(seed), 1'b1);
        run(RW_WRITE, CFG_MENU, 8'h05, $random(seed), 1'b1);
        chk(32'(cfg_pending), 32'h1);
        run(RW_WRITE, CFG_MENU, RESET_PARAM, RESET_VALUE, 1'b1);
        chk(32'(mr_count), 32'h1);
        chk(32'(cfg_pending), 32'h0);
        poke(16'h1101, 16'h1101);
        chk(32'(b_menu), 32'h01);
        poke(16'h1305, 16'h1101);
        chk(32'(b_menu), 32'h01);
        poke(16'h0000, 16'h0000);
        poke(16'h1102, 16'h1102);
        give_verdict;
    end
    // Whole run needs under 1400 ns; this is far beyond it
    initial
    begin
        #100000;
        miscompares++;
        give_verdict;
    end
endmodule
